// ---- rtl/cmd_map.vh ----
/*
 Constants for the core memory map decoder: offsets, field positions,
 reset values and sizes. Assumes inclusion by bare name from rtl/.
*/
// What this block does
// - Parity bit is one when accumulator holds an odd number of ones.
// - Four serial bytes form one 32-bit value, byte3 most significant.
// - Serial bytes decode at special addresses 0xf9 to 0xfc, page 0x0f.
// - Serial bytes load the per-part value and accept software writes.
// - Program Flash spans 0x0000 to 0xffff, or 0x7fff on small variant.
// - Lock byte sits at 0xfbff, or top address on the small variant.
// - Large variant program addresses above 0xfdff are reserved.
// - Code-space reads always go to program Flash.
// - External-data moves hit expanded RAM, or write/erase Flash if set.
// - Provide 256 bytes internal RAM and 4096 bytes expanded RAM.
// - Addresses below 0x80 reach RAM for direct and indirect access.
// - Above 0x7f, indirect hits upper RAM, direct hits special space.
// - Bytes 0x00 to 0x1f are four banks chosen by status bits 3, 4.
// - One bank active; register operands go to the selected bank.
// - Indirect access takes its address from register 0 or 1.
// - Bit addresses 0x00 to 0x7f map to byte 0x20 plus address/8.
// - Bit versus byte access follows operand type, not address.
// - Push writes at pointer plus one, then increments the pointer.
// - Reset loads stack pointer with 0x07; first push lands at 0x08.
// - Stack may sit anywhere in internal RAM, up to 256 bytes deep.
`ifndef CMD_MAP_VH
`define CMD_MAP_VH
`define CMD_SN0_ADDR 8'hf9
`define CMD_SN1_ADDR 8'hfa
`define CMD_SN2_ADDR 8'hfb
`define CMD_SN3_ADDR 8'hfc
`define CMD_SN_PAGE 8'h0f
`define CMD_SP_RESET 8'h07
`define CMD_SP_ADDR 8'h81
`define CMD_PSW_ADDR 8'hd0
`define CMD_ACC_ADDR 8'he0
`define CMD_PSW_PAR_BIT 0
`define CMD_PSW_BSL_BIT 3
`define CMD_PSW_BSH_BIT 4
`define CMD_BIT_BASE 8'h20
`define CMD_LOWER_TOP 8'h7f
`define CMD_PROG_TOP_BIG 16'hffff
`define CMD_PROG_TOP_SMALL 16'h7fff
`define CMD_LOCK_BIG 16'hfbff
`define CMD_LOCK_SMALL 16'h7fff
`define CMD_RSVD_ABOVE 16'hfdff
`define CMD_EXPANDED_DATA_RAM_DEPTH 4096
`define CMD_EXPANDED_DATA_RAM_AW 12
`define CMD_IRAM_DEPTH 256
`define CMD_SN_DEFAULT 32'h1234abcd
`endif

// ---- rtl/cmd_ram.v ----
/*
 Single-port synchronous byte memory used for internal and expanded RAM.
 Assumes one access per cycle; read data valid one cycle after request.
*/
`timescale 1ns/1ns
module cmd_ram #(
   parameter AW = 8,
   parameter DEPTH = 256
) (
   input wire clk,
   input wire we,
   input wire [AW-1:0] addr,
   input wire [7:0] wdata,
   output reg [7:0] rdata
);
   reg [7:0] mem [0:DEPTH-1];

   always @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// ---- rtl/cmd_prog_dec.v ----
/*
 Program address classifier: range, lock byte and reserved area.
 Assumes the variant select is static while running.
*/
`timescale 1ns/1ns
`include "cmd_map.vh"
module cmd_prog_dec (
   input wire small_part,
   input wire [15:0] paddr,
   output wire in_range,
   output wire is_lock,
   output wire is_rsvd
);
   // Flash contiguous from zero
   assign in_range = small_part ? (paddr <= `CMD_PROG_TOP_SMALL) :
                     (paddr <= `CMD_PROG_TOP_BIG);
   assign is_lock = small_part ? (paddr == `CMD_LOCK_SMALL) :
                    (paddr == `CMD_LOCK_BIG);
   assign is_rsvd = !small_part && (paddr > `CMD_RSVD_ABOVE);
endmodule

// ---- rtl/cmd_core.v ----
/*
 Memory-map decoder of the core: internal RAM with banks, bit area and
 stack, serial-number bytes, parity, expanded RAM and program routing.
 Assumes the execution core issues at most one request per cycle and
 holds no request while a previous read answer is pending.
*/
`timescale 1ns/1ns
`include "cmd_map.vh"
module cmd_core #(
   parameter [31:0] SN_VALUE = `CMD_SN_DEFAULT
) (
   input wire clk,
   input wire nrst,
   input wire small_part,
   input wire req,
   input wire req_we,
   input wire [2:0] req_mode,
   input wire [7:0] req_addr,
   input wire [2:0] req_reg,
   input wire req_bit,
   input wire [7:0] req_wdata,
   input wire [7:0] sfr_page,
   input wire [7:0] acc,
   input wire x_req,
   input wire x_we,
   input wire x_code,
   input wire x_flash_wr_en,
   input wire [15:0] x_addr,
   input wire [7:0] x_wdata,
   output reg rd_valid,
   output reg [7:0] rd_data,
   output reg [7:0] stack_pointer,
   output reg [7:0] program_status_word,
   output reg [31:0] serial_id_bits,
   output reg sfr_ext_sel,
   output reg x_rd_valid,
   output reg [7:0] x_rd_data,
   output reg flash_rd,
   output reg flash_wr,
   output reg [15:0] flash_addr,
   output reg [7:0] flash_wdata,
   output reg flash_lock_hit,
   output reg flash_rsvd_hit
);
   // Access kinds issued by the core
   localparam [2:0] M_DIRECT = 3'h0;
   localparam [2:0] M_INDIR = 3'h1;
   localparam [2:0] M_REG = 3'h2;
   localparam [2:0] M_PUSH = 3'h3;
   localparam [2:0] M_POP = 3'h4;

   // Read source selected for the next cycle
   localparam [1:0] S_RAM = 2'h0;
   localparam [1:0] S_REG = 2'h1;
   localparam [1:0] S_NONE = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function [7:0] bank_addr;
      input [1:0] bank;
      input [2:0] rn;
      begin
         bank_addr = {3'h0, bank, rn};
      end
   endfunction

   function [7:0] bit_byte;
      input [7:0] baddr;
      begin
         bit_byte = `CMD_BIT_BASE + {4'h0, baddr[6:3]};
      end
   endfunction

   // Lower half of the direct space is plain RAM
   function in_lower;
      input [7:0] a;
      begin
         in_lower = (a <= `CMD_LOWER_TOP);
      end
   endfunction

   // Serial bytes only answer on their own page
   function sn_hit;
      input [7:0] page;
      input [7:0] a;
      input [7:0] target;
      begin
         sn_hit = (page == `CMD_SN_PAGE) && (a == target);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register bank mirror, needed for indirect address lookup

   reg [7:0] bank_r [0:31];
   wire [1:0] bank_sel = {program_status_word[`CMD_PSW_BSH_BIT],
                          program_status_word[`CMD_PSW_BSL_BIT]};
   wire [7:0] ind_ptr = bank_r[{bank_sel, 2'h0, req_reg[0]}];

   ////////////////////////////////////////////////////////////////////////
   // Request decode

   reg ram_we;
   reg [7:0] ram_addr;
   reg [7:0] ram_wdata;
   reg [1:0] src_nxt;
   reg [7:0] reg_rdata_nxt;
   reg [2:0] bitpos_nxt;
   reg bit_nxt;
   reg sp_write;
   reg [7:0] sp_nxt;
   reg psw_write;
   reg [7:0] psw_wval;
   reg [3:0] sn_we;
   reg ext_nxt;
   reg [7:0] byte_a;
   reg direct_hi;

   always @* begin
      ram_we = 1'b0;
      ram_addr = 8'h00;
      ram_wdata = req_wdata;
      src_nxt = S_NONE;
      reg_rdata_nxt = 8'h00;
      bitpos_nxt = 3'h0;
      bit_nxt = 1'b0;
      sp_write = 1'b0;
      sp_nxt = stack_pointer;
      psw_write = 1'b0;
      psw_wval = req_wdata;
      sn_we = 4'h0;
      ext_nxt = 1'b0;
      byte_a = req_addr;
      direct_hi = 1'b0;
      if (req) begin
         if (req_mode == M_PUSH) begin
            // Pointer wraps inside 256 bytes
            sp_nxt = stack_pointer + 8'h01;
            ram_addr = sp_nxt;
            ram_we = 1'b1;
            sp_write = 1'b1;
         end else if (req_mode == M_POP) begin
            ram_addr = stack_pointer;
            src_nxt = S_RAM;
            sp_nxt = stack_pointer - 8'h01;
            sp_write = 1'b1;
         end else if (req_mode == M_REG) begin
            ram_addr = bank_addr(bank_sel, req_reg);
            ram_we = req_we;
            src_nxt = S_RAM;
         end else if (req_mode == M_INDIR) begin
            ram_addr = ind_ptr;
            ram_we = req_we;
            src_nxt = S_RAM;
         end else begin
            // Bit operand type decides, not address value
            if (req_bit) begin
               if (in_lower(req_addr)) begin
                  byte_a = bit_byte(req_addr);
               end else begin
                  byte_a = {req_addr[7:3], 3'h0};
               end
               bitpos_nxt = req_addr[2:0];
               bit_nxt = 1'b1;
            end
            if (in_lower(byte_a)) begin
               ram_addr = byte_a;
               src_nxt = S_RAM;
               // Bit write becomes read-modify-write in the core
               ram_we = req_we && !req_bit;
            end else begin
               direct_hi = 1'b1;
            end
         end
         if (direct_hi) begin
            src_nxt = S_REG;
            if (byte_a == `CMD_SP_ADDR) begin
               reg_rdata_nxt = stack_pointer;
               sp_write = req_we && !req_bit;
               sp_nxt = req_wdata;
            end else if (byte_a == `CMD_PSW_ADDR) begin
               reg_rdata_nxt = program_status_word;
               psw_write = req_we;
               if (req_bit) begin
                  psw_wval = program_status_word;
                  psw_wval[req_addr[2:0]] = req_wdata[0];
               end
            end else if (byte_a == `CMD_ACC_ADDR) begin
               reg_rdata_nxt = acc;
            end else if (sn_hit(sfr_page, byte_a, `CMD_SN0_ADDR)) begin
               reg_rdata_nxt = serial_id_bits[7:0];
               sn_we[0] = req_we && !req_bit;
            end else if (sn_hit(sfr_page, byte_a, `CMD_SN1_ADDR)) begin
               reg_rdata_nxt = serial_id_bits[15:8];
               sn_we[1] = req_we && !req_bit;
            end else if (sn_hit(sfr_page, byte_a, `CMD_SN2_ADDR)) begin
               reg_rdata_nxt = serial_id_bits[23:16];
               sn_we[2] = req_we && !req_bit;
            end else if (sn_hit(sfr_page, byte_a, `CMD_SN3_ADDR)) begin
               reg_rdata_nxt = serial_id_bits[31:24];
               sn_we[3] = req_we && !req_bit;
            end else begin
               // Other special registers live elsewhere
               src_nxt = S_NONE;
               ext_nxt = 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Internal RAM, 256 bytes

   wire [7:0] ram_rdata;

   cmd_ram #(
      .AW(8),
      .DEPTH(`CMD_IRAM_DEPTH)
   ) u_iram (
      .clk(clk),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(ram_wdata),
      .rdata(ram_rdata)
   );

   // Bank copy lets indirect pointers skip a RAM read cycle
   always @(posedge clk) begin
      if (ram_we && ram_addr[7:5] == 3'h0) begin
         bank_r[ram_addr[4:0]] <= ram_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers and read answer

   reg [1:0] src_r;
   reg [7:0] reg_rdata_r;
   reg [2:0] bitpos_r;
   reg bit_r;
   wire [7:0] ram_word = bit_r ? {7'h00, ram_rdata[bitpos_r]} : ram_rdata;
   wire [7:0] psw_nxt = psw_write ? psw_wval : program_status_word;
   wire [7:0] acc_par = {7'h00, ^acc};

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         src_r <= S_NONE;
         reg_rdata_r <= 8'h00;
         bitpos_r <= 3'h0;
         bit_r <= 1'b0;
         stack_pointer <= `CMD_SP_RESET;
         program_status_word <= 8'h00;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
         sfr_ext_sel <= 1'b0;
      end else begin
         src_r <= src_nxt;
         reg_rdata_r <= bit_nxt ? {7'h00, reg_rdata_nxt[bitpos_nxt]} :
                        reg_rdata_nxt;
         bitpos_r <= bitpos_nxt;
         bit_r <= bit_nxt;
         if (sp_write) begin
            stack_pointer <= sp_nxt;
         end
         // Parity follows the accumulator every cycle
         program_status_word <= (psw_nxt & 8'hfe) | acc_par;
         sfr_ext_sel <= ext_nxt;
         rd_valid <= (src_r != S_NONE);
         rd_data <= (src_r == S_RAM) ? ram_word :
                    (src_r == S_REG) ? reg_rdata_r : 8'h00;
      end
   end

   // Serial bytes: per-part value at reset, writable afterwards
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         serial_id_bits <= SN_VALUE;
      end else begin
         if (sn_we[0]) serial_id_bits[7:0] <= req_wdata;
         if (sn_we[1]) serial_id_bits[15:8] <= req_wdata;
         if (sn_we[2]) serial_id_bits[23:16] <= req_wdata;
         if (sn_we[3]) serial_id_bits[31:24] <= req_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // External-data and code-space routing

   wire p_in;
   wire p_lock;
   wire p_rsvd;

   cmd_prog_dec u_pdec (
      .small_part(small_part),
      .paddr(x_addr),
      .in_range(p_in),
      .is_lock(p_lock),
      .is_rsvd(p_rsvd)
   );

   // Code reads always Flash; data writes to Flash only when enabled
   wire to_flash_rd = x_req && x_code;
   wire to_flash_wr = x_req && !x_code && x_we && x_flash_wr_en;
   wire to_expanded_data_ram = x_req && !x_code && !to_flash_wr;
   wire [7:0] expanded_data_ram_rdata;
   reg expanded_data_ram_pend_r;

   cmd_ram #(
      .AW(`CMD_EXPANDED_DATA_RAM_AW),
      .DEPTH(`CMD_EXPANDED_DATA_RAM_DEPTH)
   ) u_expanded_data_ram (
      .clk(clk),
      .we(to_expanded_data_ram && x_we),
      .addr(x_addr[`CMD_EXPANDED_DATA_RAM_AW-1:0]),
      .wdata(x_wdata),
      .rdata(expanded_data_ram_rdata)
   );

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         expanded_data_ram_pend_r <= 1'b0;
         x_rd_valid <= 1'b0;
         x_rd_data <= 8'h00;
         flash_rd <= 1'b0;
         flash_wr <= 1'b0;
         flash_addr <= 16'h0000;
         flash_wdata <= 8'h00;
         flash_lock_hit <= 1'b0;
         flash_rsvd_hit <= 1'b0;
      end else begin
         expanded_data_ram_pend_r <= to_expanded_data_ram && !x_we;
         x_rd_valid <= expanded_data_ram_pend_r;
         x_rd_data <= expanded_data_ram_pend_r ? expanded_data_ram_rdata : 8'h00;
         flash_rd <= to_flash_rd && p_in && !p_rsvd;
         flash_wr <= to_flash_wr && p_in && !p_rsvd;
         flash_addr <= x_addr;
         flash_wdata <= x_wdata;
         flash_lock_hit <= (to_flash_rd || to_flash_wr) && p_lock;
         flash_rsvd_hit <= (to_flash_rd || to_flash_wr) &&
                           (p_rsvd || !p_in);
      end
   end
endmodule

// ---- tb/cmd_core_assertions.sv ----
/*
 Port checks for the memory-map decoder.
 Assumes a bind to cmd_core; one clock, nrst async low.
*/
`timescale 1ns/1ns
module cmd_core_assertions (
   input wire clk,
   input wire nrst,
   input wire small_part,
   input wire req,
   input wire req_we,
   input wire [2:0] req_mode,
   input wire [7:0] req_addr,
   input wire req_bit,
   input wire [7:0] req_wdata,
   input wire [7:0] sfr_page,
   input wire [7:0] acc,
   input wire x_req,
   input wire x_we,
   input wire x_code,
   input wire x_flash_wr_en,
   input wire [15:0] x_addr,
   input wire rd_valid,
   input wire [7:0] stack_pointer,
   input wire [7:0] program_status_word,
   input wire [31:0] serial_id_bits,
   input wire sfr_ext_sel,
   input wire flash_rd,
   input wire flash_wr,
   input wire [15:0] flash_addr,
   input wire flash_lock_hit,
   input wire flash_rsvd_hit
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   wire dir = req && req_mode == 3'd0 && !req_bit;
   wire sn_wr = dir && req_we && sfr_page == 8'h0f;
   // Flash is touched only by code reads and enabled data writes
   wire fl = x_req && (x_code || (x_we && x_flash_wr_en));
   wire [15:0] top = small_part ? 16'h7fff : 16'hfdff;
//////////////////////////////////////////////////////////////////////////////
   property p_parity;
      $past(nrst) |-> program_status_word[0] == ^$past(acc);
   endproperty
   a_parity: assert property (p_parity) else $error("parity");
   property p_sp_rst;
      !$past(nrst) |-> stack_pointer == 8'h07;
   endproperty
   a_sp_rst: assert property (p_sp_rst) else $error("sp reset");
   property p_push;
      req && req_mode == 3'd3 |=> stack_pointer == $past(stack_pointer) + 8'h01;
   endproperty
   a_push: assert property (p_push) else $error("push");
   property p_pop;
      req && req_mode == 3'd4 |=>
         stack_pointer == $past(stack_pointer) - 8'h01 ##[1:2] rd_valid;
   endproperty
   a_pop: assert property (p_pop) else $error("pop");
   property p_sn_lo;
      sn_wr && req_addr == 8'hf9 |=> serial_id_bits[7:0] == $past(req_wdata);
   endproperty
   a_sn_lo: assert property (p_sn_lo) else $error("sn lo");
   property p_sn_hi;
      sn_wr && req_addr == 8'hfc |=> serial_id_bits[31:24] == $past(req_wdata);
   endproperty
   a_sn_hi: assert property (p_sn_hi) else $error("sn hi");
   property p_sn_page;
      dir && sfr_page != 8'h0f && req_addr inside {[8'hf9:8'hfc]} |=>
         sfr_ext_sel ##1 !rd_valid [*2];
   endproperty
   a_sn_page: assert property (p_sn_page) else $error("page");
   property p_low;
      req && req_mode == 3'd0 && req_addr < 8'h80 |=>
         !sfr_ext_sel ##[1:2] rd_valid;
   endproperty
   a_low: assert property (p_low) else $error("low ram");
   property p_code;
      x_req && x_code && x_addr <= top |=>
         flash_rd && flash_addr == $past(x_addr);
   endproperty
   a_code: assert property (p_code) else $error("code read");
   property p_lock;
      fl && x_addr == (small_part ? 16'h7fff : 16'hfbff) |=> flash_lock_hit;
   endproperty
   a_lock: assert property (p_lock) else $error("lock");
   property p_rsvd;
      fl && x_addr > top |=> flash_rsvd_hit && !flash_rd && !flash_wr;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved");
endmodule

// ---- tb/cmd_exec_model.sv ----
/*
 Execution-core model issuing data-bus requests one at a time.
 Assumes callers enter its task from the bench's main thread.
*/
`timescale 1ns/1ns
module cmd_exec_model (
   input wire clk,
   input wire rd_valid,
   input wire [7:0] rd_data,
   input wire sfr_ext_sel,
   output reg req,
   output reg req_we,
   output reg [2:0] req_mode,
   output reg [7:0] req_addr,
   output reg [2:0] req_reg,
   output reg req_bit,
   output reg [7:0] req_wdata
);
   reg ext;
   reg [7:0] q;
   integer i;
   initial begin
      {req, req_we, req_mode, req_addr, req_reg, req_bit, req_wdata} = 0;
   end
   task access(input [2:0] m, input w, input b, input [7:0] a,
      input [7:0] d);
      begin
         @(negedge clk);
         {req, req_we, req_mode, req_bit, req_addr, req_wdata} =
            {1'b1, w, m, b, a, d};
         req_reg = a[2:0];
         @(negedge clk);
         // Released lines flip so stale values are never trusted
         {req, req_addr, req_wdata} = {1'b0, ~a, ~d};
         // Refusal pulse stands only in the cycle after the taking edge
         ext = (sfr_ext_sel === 1'b1);
         q = 8'hxx;
         for (i = 0; i < 3; i = i + 1) begin
            @(negedge clk);
            if (rd_valid === 1'b1) q = rd_data;
            if (sfr_ext_sel === 1'b1) ext = 1;
         end
      end
   endtask
endmodule

// ---- tb/tb.sv ----
/*
 Self-checking bench for cmd_core against an integer memory model.
 Assumes cmd_exec_model drives the data bus; inputs move at negedge.
*/
`timescale 1ns/1ns
`define PM cmd_exec_model_inst
`define CHK(n, e, s) begin \
   checks_done = checks_done + 1; \
   if ((s) !== (e)) begin \
      miscompares = miscompares + 1; \
      $display("wrong value %s exp %h got %h", n, e, s); \
   end \
end
module tb;
   localparam [31:0] SNV = 32'h13572468; // Arbitrary serial value
   reg clk = 0;
   reg nrst = 0;
   reg small_part = 0;
   reg [7:0] sfr_page = 8'h0f;
   reg [7:0] acc = 0;
   reg x_req = 0;
   reg x_we = 0;
   reg x_code = 0;
   reg x_flash_wr_en = 0;
   reg [15:0] x_addr = 0;
   reg [7:0] x_wdata = 0;
   wire req, req_we, req_bit, rd_valid, sfr_ext_sel, x_rd_valid;
   wire flash_rd, flash_wr, flash_lock_hit, flash_rsvd_hit;
   wire [2:0] req_mode, req_reg;
   wire [7:0] req_addr, req_wdata, rd_data, stack_pointer, x_rd_data;
   wire [7:0] program_status_word, flash_wdata;
   wire [15:0] flash_addr;
   wire [31:0] serial_id_bits;
   integer seed, miscompares, checks_done, cycles, i, d, sp;
   int mem[256];
   reg [7:0] sn [0:3];
   reg [3:0] fl;
   reg [15:0] fa;
   reg xv;
   reg [7:0] xd;
   reg [7:0] fw;
   cmd_core #(.SN_VALUE(SNV)) cmd_core_inst (.clk(clk), .nrst(nrst),
      .small_part(small_part), .req(req), .req_we(req_we),
      .req_mode(req_mode), .req_addr(req_addr), .req_reg(req_reg),
      .req_bit(req_bit), .req_wdata(req_wdata), .sfr_page(sfr_page),
      .acc(acc), .x_req(x_req), .x_we(x_we), .x_code(x_code),
      .x_flash_wr_en(x_flash_wr_en), .x_addr(x_addr), .x_wdata(x_wdata),
      .rd_valid(rd_valid), .rd_data(rd_data), .stack_pointer(stack_pointer),
      .program_status_word(program_status_word),
      .serial_id_bits(serial_id_bits), .sfr_ext_sel(sfr_ext_sel),
      .x_rd_valid(x_rd_valid), .x_rd_data(x_rd_data), .flash_rd(flash_rd),
      .flash_wr(flash_wr), .flash_addr(flash_addr),
      .flash_wdata(flash_wdata), .flash_lock_hit(flash_lock_hit),
      .flash_rsvd_hit(flash_rsvd_hit));
   cmd_exec_model cmd_exec_model_inst (.clk(clk), .rd_valid(rd_valid),
      .rd_data(rd_data), .sfr_ext_sel(sfr_ext_sel), .req(req),
      .req_we(req_we), .req_mode(req_mode), .req_addr(req_addr),
      .req_reg(req_reg), .req_bit(req_bit), .req_wdata(req_wdata));
   always #50 clk = ~clk;
   initial cycles = 0;
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 4000) begin
         miscompares = miscompares + 1;
         conclude;
      end
   end
   task conclude;
      begin
         $display("checks %0d mismatches %0d", checks_done, miscompares);
         if (miscompares == 0 && checks_done > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task xop(input w, input c, input [15:0] a, input [7:0] v);
      begin
         @(negedge clk);
         {x_req, x_we, x_code, x_addr, x_wdata} = {1'b1, w, c, a, v};
         @(negedge clk);
         {x_req, x_addr, x_wdata} = {1'b0, ~a, ~v};
         fl = {flash_rd, flash_wr, flash_lock_hit, flash_rsvd_hit};
         fa = flash_addr;
         fw = flash_wdata;
         xv = 0;
         repeat (2) begin
            @(negedge clk);
            if (x_rd_valid === 1'b1) {xv, xd} = {1'b1, x_rd_data};
         end
      end
   endtask
//////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 26;
      miscompares = 0;
      checks_done = 0;
      repeat (2) @(negedge clk);
      nrst = 1;
      `CHK("sp", 8'h07, stack_pointer)
      `CHK("sn", SNV, serial_id_bits)
      sp = 7;
      for (i = 0; i < 5; i = i + 1) begin
         // Late relocation makes the stack wrap past the top byte
         if (i == 3) begin
            `PM.access(0, 1, 0, 8'h81, 8'hfe);
            sp = 254;
         end
         d = $random(seed) & 255;
         `PM.access(3, 1, 0, 0, d);
         sp = (sp + 1) & 255;
         mem[sp] = d;
         `CHK("sp", sp, stack_pointer)
      end
      `PM.access(0, 0, 0, 8'h08, 0);
      `CHK("first", mem[8], `PM.q)
      for (i = 0; i < 2; i = i + 1) begin
         `PM.access(4, 0, 0, 0, 0);
         `CHK("pop", mem[sp], `PM.q)
         sp = (sp - 1) & 255;
      end
      `CHK("wrap", sp, stack_pointer)
      `PM.access(0, 0, 0, 8'h81, 0);
      `CHK("spdir", sp, `PM.q)
      for (i = 0; i < 8; i = i + 1) begin
         acc = $random(seed);
         @(negedge clk);
         `CHK("par", ^acc, program_status_word[0])
      end
      acc = 0;
      for (i = 0; i < 4; i = i + 1) begin
         sn[i] = $random(seed);
         `PM.access(0, 1, 0, 8'hf9 + i[7:0], sn[i]);
      end
      `CHK("sn", {sn[3], sn[2], sn[1], sn[0]}, serial_id_bits)
      for (i = 0; i < 4; i = i + 1) begin
         `PM.access(0, 0, 0, 8'hf9 + i[7:0], 0);
         `CHK("snrd", sn[i], `PM.q)
      end
      sfr_page = 8'h00;
      `PM.access(0, 1, 0, 8'hfc, 8'h55);
      `CHK("refuse", 1'b1, `PM.ext)
      `CHK("kept", sn[3], serial_id_bits[31:24])
      sfr_page = 8'h0f;
      for (i = 0; i < 4; i = i + 1) begin
         `PM.access(0, 1, 0, 8'hd0, i << 3);
         d = $random(seed) & 255;
         `PM.access(2, 1, 0, 2, d);
         mem[i * 8 + 2] = d;
         `CHK("bank", i[1:0], program_status_word[4:3])
         `PM.access(0, 0, 0, i * 8 + 2, 0);
         `CHK("rn", mem[i * 8 + 2], `PM.q)
      end
      `PM.access(2, 1, 0, 1, 8'h90);
      d = $random(seed) & 255;
      `PM.access(1, 1, 0, 1, d);
      `PM.access(1, 0, 0, 1, 0);
      `CHK("upper", d, `PM.q)
      `PM.access(0, 0, 0, 8'h90, 0);
      `CHK("sfr", 1'b1, `PM.ext)
      `PM.access(2, 1, 0, 0, 8'h45);
      `PM.access(0, 1, 0, 8'h45, d ^ 255);
      `PM.access(1, 0, 0, 0, 0);
      `CHK("lower", d ^ 255, `PM.q)
      d = $random(seed) & 255;
      `PM.access(0, 1, 0, 8'h22, d);
      for (i = 0; i < 8; i = i + 1) begin
         `PM.access(0, 0, 1, 8'h10 + i[7:0], 0);
         `CHK("bit", (d >> i) & 1, `PM.q[0])
      end
      `PM.access(0, 0, 0, 8'h22, 0);
      `CHK("byte", d, `PM.q)
      `PM.access(0, 1, 1, 8'hd1, 1);
      `CHK("pswbit", 1'b1, program_status_word[1])
      `PM.access(0, 0, 1, 8'hd3, 0);
      `CHK("pswrd", 1'b1, `PM.q[0])
      xop(0, 1, 16'h1234, 0);
      `CHK("code", 4'b1000, fl)
      `CHK("faddr", 16'h1234, fa)
      xop(0, 1, 16'hfbff, 0);
      `CHK("lock", 4'b1010, fl)
      xop(0, 1, 16'hfe00, 0);
      `CHK("rsvd", 4'b0001, fl)
      xop(1, 0, 16'h0abc, d);
      xop(0, 0, 16'h1abc, 0);
      `CHK("expanded_data_ram", 256 + d, {xv, xd})
      x_flash_wr_en = 1;
      xop(1, 0, 16'h0200, 8'h5a);
      `CHK("fwr", 4'b0100, fl)
      `CHK("fwdata", 8'h5a, fw)
      small_part = 1;
      xop(0, 1, 16'h7fff, 0);
      `CHK("slock", 4'b1010, fl)
      xop(0, 1, 16'h8000, 0);
      `CHK("stop", 4'b0001, fl)
      conclude;
   end
endmodule
bind cmd_core cmd_core_assertions cmd_core_assertions_inst (.clk(clk),
   .nrst(nrst), .small_part(small_part), .req(req), .req_we(req_we),
   .req_mode(req_mode), .req_addr(req_addr), .req_bit(req_bit),
   .req_wdata(req_wdata), .sfr_page(sfr_page), .acc(acc), .x_req(x_req),
   .x_we(x_we), .x_code(x_code), .x_flash_wr_en(x_flash_wr_en),
   .x_addr(x_addr), .rd_valid(rd_valid), .stack_pointer(stack_pointer),
   .program_status_word(program_status_word),
   .serial_id_bits(serial_id_bits), .sfr_ext_sel(sfr_ext_sel),
   .flash_rd(flash_rd), .flash_wr(flash_wr), .flash_addr(flash_addr),
   .flash_lock_hit(flash_lock_hit), .flash_rsvd_hit(flash_rsvd_hit));
